// ===== core/encoder_link_frame_monitor.sv
/*
  Passive monitor of a clocked encoder link: finds frames, captures control
  and sensor bits, stores frames in two banks, counts frames and flags
  errors; a host reads everything over a serial slave port.
  Assumes all pins are asynchronous to ref_clk_i, which is the internal
  oscillator, and rst_i is the internal power-up reset.
*/

// Functional notes
// - End of frame found by adaptive timeout; then interrupt request is raised if the frame reached the data phase.
// - Status byte shows which banks hold new frame data for polling.
// - Two banks: host reads last complete frame while the other fills.
// - An unfetched bank is simply overwritten; capture never stalls.
// - A 14-bit frame counter is readable over the serial port.
// - Counter advances on every end-of-frame timeout.
// - Critical errors hold the error pin until the host clears it.
// - Sample control and sensor bits correctly up to 10 Mbit/s.
// - Link clock and data lines are inputs only, never driven.
// - Serial slave port with select, clock, data in, data out.
// - Logic held in reset while the reset pin is low.
// - Power-up reset and clocks come from inside the device.
// - Line and slave delay measured per frame, no host setting.
module encoder_link_frame_monitor #(
  parameter int DATA_BITS = 64
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic reset_in_n_i,
  input  wire logic test_mode_in_n_i,
  input  wire logic line_clock_in_p_i,
  input  wire logic line_clock_in_n_i,
  input  wire logic line_data_in_p_i,
  input  wire logic line_data_in_n_i,
  input  wire logic spi_cs_n_i,
  input  wire logic spi_sclk_i,
  input  wire logic spi_mosi_i,
  output logic      spi_miso_o,
  output logic      spi_miso_oe_o,
  output logic      irq_o,
  output logic      err_o
);

  localparam int DATA_BYTES = DATA_BITS / 8;
  localparam int NB_W       = $clog2(DATA_BITS + 1);
  localparam int CW         = mon_pkg::CNT_W;

  // ************************************************************
  // Pin synchronisers, reset and line receivers
  // ************************************************************
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic       rst;
  logic       clk_lvl;
  logic       dat_lvl;
  logic       clk_prev;
  logic       next_clk_lvl;
  logic       next_dat_lvl;
  logic       clk_rise;
  logic       clk_fall;
  logic       test_ok;

  always_ff @(posedge ref_clk_i) begin
    pin_s1 <= {test_mode_in_n_i, reset_in_n_i, line_data_in_n_i,
               line_data_in_p_i, line_clock_in_n_i, line_clock_in_p_i};
    pin_s2 <= pin_s1;
  end

  assign rst     = rst_i | ~pin_s2[4];
  assign test_ok = pin_s2[5];

  // Differential receiver: an invalid pair keeps the last level
  always_comb begin
    next_clk_lvl = (pin_s2[0] != pin_s2[1]) ? pin_s2[0] : clk_lvl;
    next_dat_lvl = (pin_s2[2] != pin_s2[3]) ? pin_s2[2] : dat_lvl;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      clk_lvl  <= 1'b1;
      dat_lvl  <= 1'b1;
      clk_prev <= 1'b1;
    end else begin
      clk_lvl  <= next_clk_lvl;
      dat_lvl  <= next_dat_lvl;
      clk_prev <= clk_lvl;
    end
  end

  assign clk_rise = clk_lvl & ~clk_prev;
  assign clk_fall = ~clk_lvl & clk_prev;

  // ************************************************************
  // Frame capture
  // ************************************************************
  mon_pkg::mon_state_t state;
  mon_pkg::mon_state_t next_state;
  logic [CW-1:0]        rise_cnt;
  logic [CW-1:0]        next_rise_cnt;
  logic [CW-1:0]        period;
  logic [CW-1:0]        next_period;
  logic [CW:0]          high_cnt;
  logic [CW:0]          next_high_cnt;
  logic [CW-1:0]        dly;
  logic [CW-1:0]        next_dly;
  logic                 seen_low;
  logic                 next_seen_low;
  logic [1:0]           phase;
  logic [1:0]           next_phase;
  logic [DATA_BITS-1:0] sreg;
  logic [DATA_BITS-1:0] next_sreg;
  logic [NB_W-1:0]      nbit;
  logic [NB_W-1:0]      next_nbit;
  logic                 cds;
  logic                 next_cds;
  logic [CW:0]          tmo_lim;
  logic [CW:0]          samp_raw;
  logic [CW:0]          samp_pt;
  logic                 timeout;
  logic                 samp;
  logic                 frame_done;
  logic                 frame_bad;
  logic                 overflow;

  // Timeout is 1.5 measured link periods of clock held high
  assign tmo_lim  = {1'b0, period} + {2'b00, period[CW-1:1]};
  assign timeout  = (state != mon_pkg::ST_IDLE) && (high_cnt >= tmo_lim);
  // Sample point: measured delay plus half a period, wrapped once
  assign samp_raw = {1'b0, dly} + {2'b00, period[CW-1:1]};
  assign samp_pt  = (samp_raw >= {1'b0, period}) ? samp_raw - {1'b0, period} : samp_raw;
  assign samp     = (state == mon_pkg::ST_DATA) && (rise_cnt != '1) &&
                    ({1'b0, rise_cnt} == samp_pt);

  always_comb begin
    next_state    = state;
    next_rise_cnt = (rise_cnt == '1) ? rise_cnt : rise_cnt + 1'b1;
    next_period   = period;
    next_high_cnt = (!clk_lvl) ? '0 : ((high_cnt == '1) ? high_cnt : high_cnt + 1'b1);
    next_dly      = dly;
    next_seen_low = seen_low;
    next_phase    = phase;
    next_sreg     = sreg;
    next_nbit     = nbit;
    next_cds      = cds;
    frame_done    = 1'b0;
    frame_bad     = 1'b0;
    overflow      = 1'b0;
    if (clk_rise) begin
      next_rise_cnt = '0;
      if (state != mon_pkg::ST_IDLE && rise_cnt != '1 &&
          rise_cnt >= CW'(mon_pkg::LINK_MIN_CYCLES - 1)) begin
        next_period = rise_cnt;
      end
    end
    unique case (state)
      mon_pkg::ST_IDLE: begin
        if (clk_fall && test_ok) begin
          next_state    = mon_pkg::ST_WAIT_START;
          next_seen_low = 1'b0;
          next_nbit     = '0;
          next_sreg     = '0;
          next_phase    = 2'h0;
          next_rise_cnt = '1;
        end
      end
      mon_pkg::ST_WAIT_START: begin
        if (!dat_lvl) begin
          next_seen_low = 1'b1;
        end else if (seen_low) begin
          next_state = mon_pkg::ST_DATA;
          next_dly   = rise_cnt;
        end
      end
      mon_pkg::ST_DATA: begin
        if (samp) begin
          if (phase == 2'h0) begin
            next_phase = 2'h1;
          end else if (phase == 2'h1) begin
            next_cds   = dat_lvl;
            next_phase = 2'h2;
          end else if (nbit == NB_W'(DATA_BITS)) begin
            overflow = 1'b1;
          end else begin
            next_sreg = {sreg[DATA_BITS-2:0], dat_lvl};
            next_nbit = nbit + 1'b1;
          end
        end
      end
      default: begin
        next_state = mon_pkg::ST_IDLE;
      end
    endcase
    if (timeout) begin
      next_state = mon_pkg::ST_IDLE;
      frame_done = 1'b1;
      frame_bad  = (state != mon_pkg::ST_DATA);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      state    <= mon_pkg::ST_IDLE;
      rise_cnt <= '1;
      period   <= mon_pkg::PERIOD_RST;
      high_cnt <= '0;
      dly      <= '0;
      seen_low <= 1'b0;
      phase    <= 2'h0;
      sreg     <= '0;
      nbit     <= '0;
      cds      <= 1'b0;
    end else begin
      state    <= next_state;
      rise_cnt <= next_rise_cnt;
      period   <= next_period;
      high_cnt <= next_high_cnt;
      dly      <= next_dly;
      seen_low <= next_seen_low;
      phase    <= next_phase;
      sreg     <= next_sreg;
      nbit     <= next_nbit;
      cds      <= next_cds;
    end
  end

  // ************************************************************
  // Banks, counter, flags and host reads
  // ************************************************************
  spi_port_if bus ();

  logic [DATA_BITS-1:0]    bank_data [2];
  logic [DATA_BITS-1:0]    next_bank_data [2];
  logic [NB_W-1:0]         bank_nbits [2];
  logic [NB_W-1:0]         next_bank_nbits [2];
  logic [1:0]              bank_cds;
  logic [1:0]              next_bank_cds;
  logic [1:0]              new_flag;
  logic [1:0]              next_new_flag;
  logic                    wr_bank;
  logic                    next_wr_bank;
  logic                    rd_bank;
  logic                    next_rd_bank;
  logic                    lat_bank;
  logic                    next_lat_bank;
  logic [mon_pkg::FCNT_W-1:0] frame_cnt;
  logic [mon_pkg::FCNT_W-1:0] next_frame_cnt;
  logic                    err;
  logic                    next_err;
  logic [1:0]              err_code;
  logic [1:0]              next_err_code;
  logic                    irq;
  logic                    next_irq;
  logic [7:0]              rdata;
  logic [7:0]              next_rdata;
  logic                    good;

  assign good = frame_done & ~frame_bad;

  always_comb begin
    next_bank_data  = bank_data;
    next_bank_nbits = bank_nbits;
    next_bank_cds   = bank_cds;
    next_new_flag   = new_flag;
    next_wr_bank    = wr_bank;
    next_rd_bank    = rd_bank;
    next_lat_bank   = bus.start_stb ? rd_bank : lat_bank;
    next_frame_cnt  = frame_done ? frame_cnt + 1'b1 : frame_cnt;
    next_err        = err;
    next_err_code   = err_code;
    next_irq        = irq;
    next_rdata      = rdata;
    if (bus.clr_stb) begin
      next_err      = 1'b0;
      next_err_code = 2'b00;
    end
    if (bus.rd_stb) begin
      if (bus.addr == mon_pkg::ADDR_STATUS) begin
        next_irq = 1'b0;
      end
      if (bus.addr == 7'(DATA_BYTES - 1)) begin
        next_new_flag[lat_bank] = 1'b0;
      end
      if (bus.addr < 7'(DATA_BYTES)) begin
        next_rdata = bank_data[lat_bank][8*bus.addr +: 8];
      end else begin
        unique case (bus.addr)
          mon_pkg::ADDR_STATUS:  next_rdata = {err, irq, 2'b00, bank_cds[lat_bank],
                                               lat_bank, new_flag};
          mon_pkg::ADDR_CNT_LO:  next_rdata = frame_cnt[7:0];
          mon_pkg::ADDR_CNT_HI:  next_rdata = {2'b00, frame_cnt[13:8]};
          mon_pkg::ADDR_NBITS:   next_rdata = 8'(bank_nbits[lat_bank]);
          mon_pkg::ADDR_ERRCODE: next_rdata = {6'h00, err_code};
          default:               next_rdata = 8'h00;
        endcase
      end
    end
    // Events win over a clear in the same cycle
    if (frame_bad | overflow) begin
      next_err = 1'b1;
      next_err_code[mon_pkg::EC_NOSTART]  = err_code[mon_pkg::EC_NOSTART] | frame_bad;
      next_err_code[mon_pkg::EC_OVERFLOW] = err_code[mon_pkg::EC_OVERFLOW] | overflow;
    end
    if (good) begin
      next_bank_data[wr_bank]  = sreg;
      next_bank_nbits[wr_bank] = nbit;
      next_bank_cds[wr_bank]   = cds;
      next_new_flag[wr_bank]   = 1'b1;
      next_rd_bank             = wr_bank;
      next_wr_bank             = ~wr_bank;
      next_irq                 = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst) begin
      bank_data  <= '{default: '0};
      bank_nbits <= '{default: '0};
      bank_cds   <= 2'b00;
      new_flag   <= 2'b00;
      wr_bank    <= 1'b0;
      rd_bank    <= 1'b1;
      lat_bank   <= 1'b1;
      frame_cnt  <= mon_pkg::FCNT_RST;
      err        <= 1'b0;
      err_code   <= 2'b00;
      irq        <= 1'b0;
      rdata      <= 8'h00;
    end else begin
      bank_data  <= next_bank_data;
      bank_nbits <= next_bank_nbits;
      bank_cds   <= next_bank_cds;
      new_flag   <= next_new_flag;
      wr_bank    <= next_wr_bank;
      rd_bank    <= next_rd_bank;
      lat_bank   <= next_lat_bank;
      frame_cnt  <= next_frame_cnt;
      err        <= next_err;
      err_code   <= next_err_code;
      irq        <= next_irq;
      rdata      <= next_rdata;
    end
  end

  assign bus.rdata = rdata;
  assign irq_o     = irq;
  assign err_o     = err;

  spi_slave_port u_spi (
    .ref_clk_i     (ref_clk_i),
    .rst_i         (rst),
    .spi_cs_n_i    (spi_cs_n_i),
    .spi_sclk_i    (spi_sclk_i),
    .spi_mosi_i    (spi_mosi_i),
    .spi_miso_o    (spi_miso_o),
    .spi_miso_oe_o (spi_miso_oe_o),
    .bus           (bus)
  );

endmodule : encoder_link_frame_monitor

// ===== core/mon_pkg.sv
/*
  Shared constants and types of the encoder link frame monitor: timing of the
  link, counter widths, host address map and the capture state encoding.
  Assumes a 40 MHz core clock; every user names items as mon_pkg::name.
*/
package mon_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS       = 25;
  localparam int LINK_MIN_PERIOD_NS  = 100;
  localparam int LINK_MIN_CYCLES     =
    (LINK_MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMO_NUM             = 3;
  localparam int TMO_DEN             = 2;

  // ************************************************************
  // Widths and reset values
  // ************************************************************
  localparam int              CNT_W      = 12;
  localparam int              FCNT_W     = 14;
  localparam logic [11:0]     PERIOD_RST = 12'h0C8;
  localparam logic [13:0]     FCNT_RST   = 14'h0000;

  // ************************************************************
  // Host address map (7-bit address, bit 7 of the command byte clears)
  // ************************************************************
  localparam logic [6:0] ADDR_STATUS  = 7'h40;
  localparam logic [6:0] ADDR_CNT_LO  = 7'h41;
  localparam logic [6:0] ADDR_CNT_HI  = 7'h42;
  localparam logic [6:0] ADDR_NBITS   = 7'h43;
  localparam logic [6:0] ADDR_ERRCODE = 7'h44;
  localparam int         ST_NEW0_BIT  = 0;
  localparam int         ST_NEW1_BIT  = 1;
  localparam int         ST_BANK_BIT  = 2;
  localparam int         ST_CDS_BIT   = 3;
  localparam int         ST_IRQ_BIT   = 6;
  localparam int         ST_ERR_BIT   = 7;
  localparam int         EC_NOSTART   = 0;
  localparam int         EC_OVERFLOW  = 1;

  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_WAIT_START = 2'b01,
    ST_DATA       = 2'b10
  } mon_state_t;

endpackage : mon_pkg

// ===== core/spi_port_if.sv
/*
  Byte request channel between the host serial port and the monitor core.
  Assumes both ends run on the core clock.
*/
interface spi_port_if;
  logic       cs_active;
  logic       start_stb;
  logic       rd_stb;
  logic       clr_stb;
  logic [6:0] addr;
  logic [7:0] rdata;

  modport port (
    output cs_active,
    output start_stb,
    output rd_stb,
    output clr_stb,
    output addr,
    input  rdata
  );

  modport core (
    input  cs_active,
    input  start_stb,
    input  rd_stb,
    input  clr_stb,
    input  addr,
    output rdata
  );
endinterface : spi_port_if

// ===== core/spi_slave_port.sv
/*
  Serial slave port, mode 0, MSB first: first byte is a command (bit 7 set
  clears the error latch, bits 6:0 an address), later bytes return data with
  address auto increment. Assumes pins are asynchronous to ref_clk_i.
*/
module spi_slave_port (
  input  wire logic  ref_clk_i,
  input  wire logic  rst_i,
  input  wire logic  spi_cs_n_i,
  input  wire logic  spi_sclk_i,
  input  wire logic  spi_mosi_i,
  output logic       spi_miso_o,
  output logic       spi_miso_oe_o,
  spi_port_if.port   bus
);

  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic       sclk_prev;
  logic       cs_prev;
  logic [2:0] bit_cnt;
  logic       first;
  logic       load_pend;
  logic [7:0] rx;
  logic [7:0] tx;
  logic [6:0] addr;
  logic       rd_stb;
  logic       clr_stb;
  logic       start_stb;
  logic [2:0] next_bit_cnt;
  logic       next_first;
  logic       next_load_pend;
  logic [7:0] next_rx;
  logic [7:0] next_tx;
  logic [6:0] next_addr;
  logic       next_rd_stb;
  logic       next_clr_stb;
  logic       next_start_stb;
  logic       cs_act;
  logic       sclk_rise;
  logic       sclk_fall;

  assign cs_act    = ~pin_s2[0];
  assign sclk_rise = pin_s2[1] & ~sclk_prev & cs_act;
  assign sclk_fall = ~pin_s2[1] & sclk_prev & cs_act;

  always_comb begin
    next_bit_cnt   = bit_cnt;
    next_first     = first;
    next_load_pend = load_pend;
    next_rx        = rx;
    next_tx        = tx;
    next_addr      = addr;
    next_rd_stb    = 1'b0;
    next_clr_stb   = 1'b0;
    next_start_stb = cs_act & ~cs_prev;
    if (cs_act & ~cs_prev) begin
      next_bit_cnt = 3'h0;
      next_first   = 1'b1;
      next_tx      = 8'h00;
    end
    if (sclk_rise) begin
      next_rx      = {rx[6:0], pin_s2[2]};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == 3'h7) begin
        next_load_pend = 1'b1;
        next_rd_stb    = 1'b1;
        next_first     = 1'b0;
        if (first) begin
          next_addr    = {rx[5:0], pin_s2[2]};
          next_clr_stb = rx[6];
        end else begin
          next_addr = addr + 7'h01;
        end
      end
    end
    if (sclk_fall) begin
      if (load_pend) begin
        next_tx        = bus.rdata;
        next_load_pend = 1'b0;
      end else begin
        next_tx = {tx[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    pin_s1 <= {spi_mosi_i, spi_sclk_i, spi_cs_n_i};
    pin_s2 <= pin_s1;
    if (rst_i) begin
      sclk_prev <= 1'b0;
      cs_prev   <= 1'b0;
      bit_cnt   <= 3'h0;
      first     <= 1'b1;
      load_pend <= 1'b0;
      rx        <= 8'h00;
      tx        <= 8'h00;
      addr      <= 7'h00;
      rd_stb    <= 1'b0;
      clr_stb   <= 1'b0;
      start_stb <= 1'b0;
    end else begin
      sclk_prev <= pin_s2[1];
      cs_prev   <= cs_act;
      bit_cnt   <= next_bit_cnt;
      first     <= next_first;
      load_pend <= next_load_pend;
      rx        <= next_rx;
      tx        <= next_tx;
      addr      <= next_addr;
      rd_stb    <= next_rd_stb;
      clr_stb   <= next_clr_stb;
      start_stb <= next_start_stb;
    end
  end

  assign bus.cs_active = cs_act;
  assign bus.start_stb = start_stb;
  assign bus.rd_stb    = rd_stb;
  assign bus.clr_stb   = clr_stb;
  assign bus.addr      = addr;
  assign spi_miso_o    = tx[7];
  assign spi_miso_oe_o = cs_act;

endmodule : spi_slave_port

// ===== tb/host_spi_model.sv
/*
  Host serial master model, mode 0, MSB first, sclk at 40 MHz / 12.
  Assumes the bench calls xfer; inputs change at core clock falls.
*/
module host_spi_model (
  input  wire logic ref_clk_i,
  input  wire logic spi_miso_i,
  output logic      spi_cs_n_o,
  output logic      spi_sclk_o,
  output logic      spi_mosi_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    spi_cs_n_o = 1'h1;
    spi_sclk_o = 1'h0;
    spi_mosi_o = 1'h0;
  end

  // Command byte, then nb bytes back; miso taken just before each rise
  task automatic xfer(input logic [7:0] cmd, input int nb, output logic [7:0] rx [4]);
    logic [7:0] tx;
    @(negedge ref_clk_i);
    spi_cs_n_o = 1'h0;
    repeat (6) @(negedge ref_clk_i);
    for (int b = 0; b <= nb; b++) begin
      tx = (b == 0) ? cmd : 8'h00;
      for (int i = 7; i >= 0; i--) begin
        spi_mosi_o = tx[i];
        repeat (6) @(negedge ref_clk_i);
        if (b > 0) begin
          rx[b-1][i] = spi_miso_i;
        end
        spi_sclk_o = 1'h1;
        repeat (6) @(negedge ref_clk_i);
        spi_sclk_o = 1'h0;
      end
    end
    repeat (6) @(negedge ref_clk_i);
    spi_cs_n_o = 1'h1;
    spi_mosi_o = ~spi_mosi_o;
    // Deselect gap, long enough for the select synchroniser
    repeat (6) @(negedge ref_clk_i);
  endtask : xfer
endmodule : host_spi_model

// ===== tb/mon_chk.sv
/*
  Port checker of the frame monitor, bound to its top module.
  Assumes a 40 MHz core clock and a 200 ns link clock period.
*/
module mon_chk #(
  parameter int DATA_BITS = 64
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic reset_in_n_i,
  input wire logic test_mode_in_n_i,
  input wire logic line_clock_in_p_i,
  input wire logic line_clock_in_n_i,
  input wire logic line_data_in_p_i,
  input wire logic line_data_in_n_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_mosi_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic irq_o,
  input wire logic err_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Length of the current high phase of the link clock
  // ************************************************************
  logic [7:0] hi_cnt;
  logic [7:0] next_hi_cnt;

  always_comb begin
    next_hi_cnt = hi_cnt;
    if (rst_i || !line_clock_in_p_i) begin
      next_hi_cnt = 8'h00;
    end else if (hi_cnt != 8'hFF) begin
      next_hi_cnt = hi_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    hi_cnt <= next_hi_cnt;
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking

  sequence cs_idle6;
    spi_cs_n_i [*6];
  endsequence

  property held(sig);
    disable iff (rst_i || !reset_in_n_i) sig ##1 cs_idle6 |-> sig;
  endproperty

  reset_outs_a: assert property (rst_i |=> !irq_o && !err_o)
    else $error("irq or err high after reset");
  pin_reset_a: assert property (!reset_in_n_i [*6] |-> !irq_o && !err_o)
    else $error("irq or err high while reset pin low");
  err_hold_a: assert property (held(err_o))
    else $error("err dropped without host access");
  irq_hold_a: assert property (held(irq_o))
    else $error("irq dropped without host access");
  irq_timeout_a: assert property (disable iff (rst_i) $rose(irq_o) |-> hi_cnt >= 8'h0C)
    else $error("irq before end of frame timeout");
  oe_off_a: assert property (disable iff (rst_i) spi_cs_n_i [*4] |-> !spi_miso_oe_o)
    else $error("miso driven while deselected");
  oe_on_a: assert property (disable iff (rst_i) $fell(spi_cs_n_i) |-> ##[1:4] spi_miso_oe_o)
    else $error("miso not driven after select");
  miso_still_a: assert property (disable iff (rst_i)
    !spi_cs_n_i && $rose(spi_sclk_i) |-> ##1 $stable(spi_miso_o) [*4])
    else $error("miso changed while sclk high");
endmodule : mon_chk

bind encoder_link_frame_monitor mon_chk #(.DATA_BITS(DATA_BITS)) i_mon_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reset_in_n_i(reset_in_n_i),
  .test_mode_in_n_i(test_mode_in_n_i), .line_clock_in_p_i(line_clock_in_p_i),
  .line_clock_in_n_i(line_clock_in_n_i), .line_data_in_p_i(line_data_in_p_i),
  .line_data_in_n_i(line_data_in_n_i), .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i),
  .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o),
  .irq_o(irq_o), .err_o(err_o));

// ===== tb/tb_top.sv
/*
  Self-checking bench of the frame monitor: link frames made here,
  host access through the serial master model.
  Assumes the design, the checker and the master model are compiled first.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         DB   = 16;
  localparam logic [7:0] STAT = {1'h0, mon_pkg::ADDR_STATUS};
  localparam logic [7:0] ERRC = {1'h0, mon_pkg::ADDR_ERRCODE};

  logic       clk   = 1'h0;
  logic       rst   = 1'h1;
  logic       rst_n = 1'h1;
  logic       tst_n = 1'h1;
  logic       lck   = 1'h1;
  logic       ldat  = 1'h1;
  logic       cs_n;
  logic       sclk;
  logic       mosi;
  logic       miso;
  logic       irq;
  logic       err;
  logic [7:0] rx [4];
  int         n_errors  = 0;
  int         cmp_count = 0;

  always #12.5 clk = ~clk;

  encoder_link_frame_monitor #(.DATA_BITS(DB)) i_encoder_link_frame_monitor (
    .ref_clk_i(clk), .rst_i(rst), .reset_in_n_i(rst_n), .test_mode_in_n_i(tst_n),
    .line_clock_in_p_i(lck), .line_clock_in_n_i(~lck),
    .line_data_in_p_i(ldat), .line_data_in_n_i(~ldat),
    .spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(), .irq_o(irq), .err_o(err));

  host_spi_model i_host_spi_model (
    .ref_clk_i(clk), .spi_miso_i(miso), .spi_cs_n_o(cs_n), .spi_sclk_o(sclk),
    .spi_mosi_o(mosi));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd(input logic [7:0] cmd, input int nb);
    i_host_spi_model.xfer(cmd, nb, rx);
  endtask : rd

  task automatic cnt_is(input logic [13:0] e);
    rd({1'h0, mon_pkg::ADDR_CNT_LO}, 2);
    chk("cnt_lo", e[7:0], rx[0]);
    chk("cnt_hi", {2'h0, e[13:8]}, rx[1]);
  endtask : cnt_is

  // Slave answer: ack, start, control bit, data MSB first, then timeout
  task automatic frame(input logic st, input logic cds, input logic [DB-1:0] v);
    logic [DB+2:0] bits;
    bits = {1'h0, st, cds, v};
    @(negedge clk);
    for (int i = DB + 2; i >= 0; i--) begin
      lck = 1'h0;
      #100;
      lck = 1'h1;
      #25;
      ldat = bits[i];
      #75;
    end
    #200;
    ldat = 1'h0;
    #400;
    ldat = 1'h1;
    #400;
  endtask : frame

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    chk("irq", 8'h00, {7'h00, irq});
    chk("err", 8'h00, {7'h00, err});
    rd(STAT, 1);
    chk("status", 8'h00, rx[0] & 8'hC3);
    cnt_is(14'h0000);
  endtask : t_reset

  task automatic t_frame();
    frame(1'h1, 1'h1, 16'hA5C3);
    chk("irq", 8'h01, {7'h00, irq});
    rd(STAT, 1);
    chk("new", 8'h01, {7'h00, rx[0][0] ^ rx[0][1]});
    chk("cds", 8'h01, {7'h00, rx[0][mon_pkg::ST_CDS_BIT]});
    chk("irq", 8'h00, {7'h00, irq});
    rd(8'h00, 2);
    chk("byte0", 8'hC3, rx[0]);
    chk("byte1", 8'hA5, rx[1]);
    cnt_is(14'h0001);
    rd({1'h0, mon_pkg::ADDR_NBITS}, 1);
    chk("nbits", 8'(DB), rx[0]);
    rd(STAT, 1);
    chk("new", 8'h00, rx[0] & 8'h03);
  endtask : t_frame

  task automatic t_overwrite();
    frame(1'h1, 1'h0, 16'h1111);
    frame(1'h1, 1'h0, 16'h2222);
    rd(STAT, 1);
    chk("new", 8'h03, rx[0] & 8'h03);
    chk("cds", 8'h00, {7'h00, rx[0][mon_pkg::ST_CDS_BIT]});
    frame(1'h1, 1'h0, 16'h3C96);
    rd(8'h00, 2);
    chk("byte0", 8'h96, rx[0]);
    chk("byte1", 8'h3C, rx[1]);
    cnt_is(14'h0004);
  endtask : t_overwrite

  task automatic t_error();
    frame(1'h0, 1'h0, 16'h0000);
    chk("err", 8'h01, {7'h00, err});
    rd(ERRC, 1);
    chk("errcode", 8'h01, rx[0] & 8'h01);
    cnt_is(14'h0005);
    rd(8'h00, 1);
    chk("byte0", 8'h96, rx[0]);
    chk("err", 8'h01, {7'h00, err});
    rd({1'h1, mon_pkg::ADDR_ERRCODE}, 1);
    chk("err", 8'h00, {7'h00, err});
  endtask : t_error

  task automatic t_pin_reset();
    frame(1'h1, 1'h1, 16'h0F0F);
    chk("irq", 8'h01, {7'h00, irq});
    rst_n = 1'h0;
    repeat (8) @(negedge clk);
    chk("irq", 8'h00, {7'h00, irq});
    rst_n = 1'h1;
    repeat (4) @(negedge clk);
    cnt_is(14'h0000);
    rd(STAT, 1);
    chk("status", 8'h00, rx[0] & 8'hC3);
  endtask : t_pin_reset

  task automatic t_test_pin();
    tst_n = 1'h0;
    repeat (4) @(negedge clk);
    frame(1'h1, 1'h0, 16'h5A5A);
    chk("irq", 8'h00, {7'h00, irq});
    cnt_is(14'h0000);
    tst_n = 1'h1;
    repeat (4) @(negedge clk);
    frame(1'h1, 1'h0, 16'h5A5A);
    chk("irq", 8'h01, {7'h00, irq});
    cnt_is(14'h0001);
  endtask : t_test_pin

  initial begin
    repeat (8) @(negedge clk);
    rst = 1'h0;
    repeat (4) @(negedge clk);
    t_reset();
    t_frame();
    t_overwrite();
    t_error();
    t_pin_reset();
    t_test_pin();
    test_done();
  end

  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    test_done();
  end
endmodule : tb_top
